// File: verilog/fcs_defines.svh
/*
 Constants of the flash command controller: register offsets, command codes,
 unlock addresses, status bit positions and timing counts.
 Assumes a 200 MHz hclk; included by its bare name.
*/
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
`define FCS_CLK_MHZ 200
`define FCS_OFF_CTRL 8'h00
`define FCS_OFF_ADDR 8'h04
`define FCS_OFF_DATA 8'h08
`define FCS_OFF_STAT 8'h0c
`define FCS_OFF_RDAT 8'h10
`define FCS_OFF_TIME 8'h14
`define FCS_OP_NONE 4'h0
`define FCS_OP_RESET 4'h1
`define FCS_OP_AUTOSEL 4'h2
`define FCS_OP_PROGRAM 4'h3
`define FCS_OP_BYPASS 4'h4
`define FCS_OP_BYP_PROG 4'h5
`define FCS_OP_BYP_EXIT 4'h6
`define FCS_OP_CHIP_ERASE 4'h7
`define FCS_OP_BLOCK_ERASE 4'h8
`define FCS_OP_ADD_BLOCK 4'h9
`define FCS_OP_SUSPEND 4'ha
`define FCS_OP_RESUME 4'hb
`define FCS_OP_CFI 4'hc
`define FCS_OP_READ 4'hd
`define FCS_OP_POLL 4'he
`define FCS_CMD_UNLOCK1 8'haa
`define FCS_CMD_UNLOCK2 8'h55
`define FCS_CMD_RESET 8'hf0
`define FCS_CMD_AUTOSEL 8'h90
`define FCS_CMD_PROGRAM 8'ha0
`define FCS_CMD_BYPASS 8'h20
`define FCS_CMD_ERASE 8'h80
`define FCS_CMD_CHIP 8'h10
`define FCS_CMD_BLOCK 8'h30
`define FCS_CMD_SUSPEND 8'hb0
`define FCS_CMD_RESUME 8'h30
`define FCS_CMD_CFI 8'h98
`define FCS_CMD_EXIT 8'h00
`define FCS_A16_FIRST 12'h555
`define FCS_A16_SECOND 12'h2aa
`define FCS_A16_CFI 12'h055
`define FCS_A8_FIRST 12'haaa
`define FCS_A8_SECOND 12'h555
`define FCS_A8_CFI 12'h0aa
`define FCS_BIT_POLL 7
`define FCS_BIT_TOGGLE 6
`define FCS_BIT_FAIL 5
`define FCS_BIT_WINDOW 3
`define FCS_BIT_ALT 2
`define FCS_PULSE_NS 60
`define FCS_PROG_MAX_US 200
`define FCS_SUSP_MAX_US 25
`define FCS_WINDOW_US 50
`endif

// File: verilog/fcs_pkg.sv
/*
 Types shared by the flash command controller modules.
 Assumes fcs_defines.svh for all numeric constants.
*/
package fcs_pkg;
  typedef enum logic [2:0] {
    FCS_IDLE = 3'b000,
    FCS_SETUP = 3'b001,
    FCS_STROBE = 3'b011,
    FCS_HOLD = 3'b010,
    FCS_GAP = 3'b110
  } fcs_cyc_t;
  typedef enum logic [2:0] {
    FCS_SQ_IDLE = 3'b000,
    FCS_SQ_ISSUE = 3'b001,
    FCS_SQ_WAIT = 3'b011,
    FCS_SQ_POLL = 3'b010,
    FCS_SQ_CHECK = 3'b110
  } fcs_seq_t;
endpackage

// File: verilog/fcs_bus_if.sv
/*
 Carrier between the sequencer and the pin cycle engine.
 Assumes one hclk domain; one request at a time, handshake by req and done.
*/
`timescale 1ns/10ps
`default_nettype none
interface fcs_bus_if;
  logic req;
  logic wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// File: verilog/fcs_cycle.sv
/*
 Pin cycle engine: turns one read or write request into a chip enable,
 write or output enable pulse on the flash bus.
 Assumes data pins arrive asynchronously and pass three flops here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_cycle #(
  parameter int PULSE_CYC = (`FCS_PULSE_NS * `FCS_CLK_MHZ + 999) / 1000
) (
  input wire logic hclk,
  input wire logic hresetn,
  fcs_bus_if.eng bus,
  output logic [20:0] f_addr,
  output logic [15:0] f_dq_out,
  output logic f_dq_oe_n,
  input wire logic [15:0] f_dq_in,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n
);
  fcs_pkg::fcs_cyc_t st_q;
  logic [7:0] cnt_q;
  logic [15:0] s1_q, s2_q, s3_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end else begin
      s1_q <= f_dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fcs_pkg::FCS_IDLE;
      cnt_q <= 8'h00;
      f_addr <= 21'h000000;
      f_dq_out <= 16'h0000;
      f_dq_oe_n <= 1'b1;
      f_ce_n <= 1'b1;
      f_we_n <= 1'b1;
      f_oe_n <= 1'b1;
      bus.done <= 1'b0;
      bus.rdata <= 16'h0000;
    end else begin
      bus.done <= 1'b0;
      unique case (st_q)
        fcs_pkg::FCS_IDLE: begin
          if (bus.req) begin
            f_addr <= bus.addr;
            f_dq_out <= bus.wdata;
            f_dq_oe_n <= !bus.wr;
            f_ce_n <= 1'b0;
            st_q <= fcs_pkg::FCS_SETUP;
          end
        end
        fcs_pkg::FCS_SETUP: begin
          f_we_n <= !f_dq_oe_n ? 1'b0 : 1'b1;
          f_oe_n <= f_dq_oe_n ? 1'b0 : 1'b1;
          cnt_q <= PULSE_CYC[7:0];
          st_q <= fcs_pkg::FCS_STROBE;
        end
        fcs_pkg::FCS_STROBE: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            st_q <= fcs_pkg::FCS_HOLD;
            cnt_q <= 8'h03;
          end
        end
        fcs_pkg::FCS_HOLD: begin
          // Read data waits three more edges so the pin synchroniser has settled.
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            if (s2_q == s3_q) begin
              bus.rdata <= s3_q;
              f_we_n <= 1'b1;
              f_oe_n <= 1'b1;
              st_q <= fcs_pkg::FCS_GAP;
            end
          end
        end
        fcs_pkg::FCS_GAP: begin
          f_ce_n <= 1'b1;
          f_dq_oe_n <= 1'b1;
          bus.done <= 1'b1;
          st_q <= fcs_pkg::FCS_IDLE;
        end
        default: st_q <= fcs_pkg::FCS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verilog/fcs_host.sv
/*
 Host-side controller of a parallel NOR flash: software orders an operation over
 AHB-Lite, the block issues its writes, unlock-prefixed except one-write and bypass-mode commands, then polls status after a program, chip erase or resume.
 Assumes one AHB-Lite master, word transfers, and a flash wired to the pin ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_host #(
  parameter int POLL_LIMIT = 400000000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [20:0] f_addr,
  output logic [15:0] f_dq_out,
  output logic f_dq_oe_n,
  input wire logic [15:0] f_dq_in,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n,
  output logic f_byte_n,
  input wire logic ready_busy_out
);
  fcs_bus_if bus ();
  fcs_pkg::fcs_seq_t sq_q;
  logic [3:0] op_q;
  logic byte_mode_q;
  logic [20:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] rdat_q;
  logic busy_q, done_q, fail_q, timeout_q, bypass_q, seen_q;
  logic [2:0] idx_q, len_q;
  logic [31:0] poll_q;
  logic [7:0] last_stat_q;
  logic ap_wr_q, ap_sel_q;
  logic [7:0] ap_off_q;
  logic [1:0] rb_s_q;
  logic rb_s3_q;
  fcs_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(bus),
    .f_addr(f_addr),
    .f_dq_out(f_dq_out),
    .f_dq_oe_n(f_dq_oe_n),
    .f_dq_in(f_dq_in),
    .f_ce_n(f_ce_n),
    .f_we_n(f_we_n),
    .f_oe_n(f_oe_n)
  );
  // Ready/busy is a pin, so it passes three flops before use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rb_s_q <= 2'b11;
      rb_s3_q <= 1'b1;
    end else begin
      rb_s_q <= {rb_s_q[0], ready_busy_out};
      rb_s3_q <= rb_s_q[1];
    end
  end
  function automatic logic [11:0] fcs_first(input logic bm);
    fcs_first = bm ? `FCS_A8_FIRST : `FCS_A16_FIRST;
  endfunction
  function automatic logic [11:0] fcs_second(input logic bm);
    fcs_second = bm ? `FCS_A8_SECOND : `FCS_A16_SECOND;
  endfunction
  logic [11:0] a1, a2;
  logic [20:0] step_addr;
  logic [7:0] step_data;
  assign a1 = fcs_first(byte_mode_q);
  assign a2 = fcs_second(byte_mode_q);
  // Address and code of write number idx_q of the ordered command; upper lines zero except where addr_q is the target.
  always_comb begin
    step_addr = {9'h000, a1};
    step_data = `FCS_CMD_UNLOCK1;
    if (idx_q == 3'd1 || idx_q == 3'd4) begin
      step_addr = {9'h000, a2};
      step_data = `FCS_CMD_UNLOCK2;
    end
    unique case (op_q)
      `FCS_OP_RESET: step_data = (idx_q == 3'd0) ? `FCS_CMD_RESET : step_data;
      `FCS_OP_AUTOSEL: step_data = (idx_q == 3'd2) ? `FCS_CMD_AUTOSEL : step_data;
      `FCS_OP_BYPASS: step_data = (idx_q == 3'd2) ? `FCS_CMD_BYPASS : step_data;
      `FCS_OP_PROGRAM: begin
        if (idx_q == 3'd2) step_data = `FCS_CMD_PROGRAM;
        if (idx_q == 3'd3) begin
          step_addr = addr_q;
          step_data = data_q[7:0];
        end
      end
      `FCS_OP_BYP_PROG: begin
        step_data = (idx_q == 3'd0) ? `FCS_CMD_PROGRAM : data_q[7:0];
        step_addr = (idx_q == 3'd0) ? 21'h000000 : addr_q;
      end
      `FCS_OP_BYP_EXIT: begin
        step_data = (idx_q == 3'd0) ? `FCS_CMD_AUTOSEL : `FCS_CMD_EXIT;
        step_addr = 21'h000000;
      end
      `FCS_OP_CHIP_ERASE, `FCS_OP_BLOCK_ERASE: begin
        if (idx_q == 3'd2) step_data = `FCS_CMD_ERASE;
        if (idx_q == 3'd3) step_data = `FCS_CMD_UNLOCK1;
        if (idx_q == 3'd5) begin
          step_data = (op_q == `FCS_OP_CHIP_ERASE) ? `FCS_CMD_CHIP : `FCS_CMD_BLOCK;
          step_addr = (op_q == `FCS_OP_CHIP_ERASE) ? {9'h000, a1} : addr_q;
        end
      end
      `FCS_OP_ADD_BLOCK: begin
        step_data = `FCS_CMD_BLOCK;
        step_addr = addr_q;
      end
      `FCS_OP_SUSPEND: step_data = `FCS_CMD_SUSPEND;
      `FCS_OP_RESUME: step_data = `FCS_CMD_RESUME;
      `FCS_OP_CFI: begin
        step_data = `FCS_CMD_CFI;
        step_addr = byte_mode_q ? {9'h000, `FCS_A8_CFI} : {9'h000, `FCS_A16_CFI};
      end
      default: begin
        step_addr = addr_q;
      end
    endcase
  end
  logic [2:0] op_len;
  always_comb begin
    unique case (op_q)
      `FCS_OP_AUTOSEL, `FCS_OP_BYPASS: op_len = 3'd3;
      `FCS_OP_PROGRAM: op_len = 3'd4;
      `FCS_OP_BYP_PROG, `FCS_OP_BYP_EXIT: op_len = 3'd2;
      `FCS_OP_CHIP_ERASE, `FCS_OP_BLOCK_ERASE: op_len = 3'd6;
      default: op_len = 3'd1;
    endcase
  end
  logic start, is_read, polls, data_step;
  assign start = ap_sel_q && ap_wr_q && ap_off_q == `FCS_OFF_CTRL && !busy_q;
  assign is_read = op_q == `FCS_OP_READ || op_q == `FCS_OP_POLL;
  assign polls = op_q == `FCS_OP_PROGRAM || op_q == `FCS_OP_BYP_PROG
    || op_q == `FCS_OP_CHIP_ERASE || op_q == `FCS_OP_RESUME;
  // Program data keeps its full width in word mode; command writes, and all writes in byte mode, zero the top byte.
  assign data_step = !byte_mode_q && ((op_q == `FCS_OP_PROGRAM && idx_q == 3'd3)
    || (op_q == `FCS_OP_BYP_PROG && idx_q == 3'd1));
  // Sequencer: issue the writes, then for program, bypass program, chip erase and resume poll the toggle flag until it stands still.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_q <= fcs_pkg::FCS_SQ_IDLE;
      op_q <= `FCS_OP_NONE;
      idx_q <= 3'd0;
      len_q <= 3'd1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      bypass_q <= 1'b0;
      seen_q <= 1'b0;
      poll_q <= 32'h00000000;
      last_stat_q <= 8'h00;
      rdat_q <= 16'h0000;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.addr <= 21'h000000;
      bus.wdata <= 16'h0000;
    end else begin
      bus.req <= 1'b0;
      unique case (sq_q)
        fcs_pkg::FCS_SQ_IDLE: begin
          if (start) begin
            op_q <= hwdata[3:0];
            busy_q <= 1'b1;
            done_q <= 1'b0;
            timeout_q <= 1'b0;
            idx_q <= 3'd0;
            sq_q <= fcs_pkg::FCS_SQ_ISSUE;
          end
        end
        fcs_pkg::FCS_SQ_ISSUE: begin
          len_q <= op_len;
          bus.req <= 1'b1;
          bus.wr <= !is_read;
          bus.addr <= step_addr;
          bus.wdata <= data_step ? data_q : {8'h00, step_data};
          sq_q <= fcs_pkg::FCS_SQ_WAIT;
        end
        fcs_pkg::FCS_SQ_WAIT: begin
          if (bus.done) begin
            if (is_read) begin
              rdat_q <= bus.rdata;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              sq_q <= fcs_pkg::FCS_SQ_IDLE;
            end else if (idx_q + 3'd1 != len_q) begin
              idx_q <= idx_q + 3'd1;
              sq_q <= fcs_pkg::FCS_SQ_ISSUE;
            end else begin
              if (op_q == `FCS_OP_BYPASS) bypass_q <= 1'b1;
              if (op_q == `FCS_OP_BYP_EXIT) bypass_q <= 1'b0;
              // A reset clears the device error; bypass mode is kept.
              if (op_q == `FCS_OP_RESET) fail_q <= 1'b0;
              poll_q <= 32'h00000000;
              last_stat_q <= 8'h00;
              seen_q <= 1'b0;
              sq_q <= polls ? fcs_pkg::FCS_SQ_POLL : fcs_pkg::FCS_SQ_IDLE;
              busy_q <= polls;
              done_q <= !polls;
            end
          end
        end
        fcs_pkg::FCS_SQ_POLL: begin
          bus.req <= 1'b1;
          bus.wr <= 1'b0;
          bus.addr <= addr_q;
          sq_q <= fcs_pkg::FCS_SQ_CHECK;
        end
        fcs_pkg::FCS_SQ_CHECK: begin
          if (poll_q != POLL_LIMIT) poll_q <= poll_q + 32'h00000001;
          if (bus.done) begin
            last_stat_q <= bus.rdata[7:0];
            rdat_q <= bus.rdata;
            seen_q <= 1'b1;
            // Two successive reads with the same toggle bit mean the operation is over.
            if (seen_q
                && bus.rdata[`FCS_BIT_TOGGLE] == last_stat_q[`FCS_BIT_TOGGLE]) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              sq_q <= fcs_pkg::FCS_SQ_IDLE;
            end else if (bus.rdata[`FCS_BIT_FAIL]) begin
              // The flag may have come up between reads, so toggle is rechecked once.
              fail_q <= 1'b1;
              sq_q <= fcs_pkg::FCS_SQ_POLL;
              last_stat_q <= bus.rdata[7:0];
              if (seen_q
                  && bus.rdata[`FCS_BIT_TOGGLE] != last_stat_q[`FCS_BIT_TOGGLE]) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                sq_q <= fcs_pkg::FCS_SQ_IDLE;
              end
            end else if (poll_q == POLL_LIMIT) begin
              timeout_q <= 1'b1;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              sq_q <= fcs_pkg::FCS_SQ_IDLE;
            end else begin
              sq_q <= fcs_pkg::FCS_SQ_POLL;
            end
          end
        end
        default: sq_q <= fcs_pkg::FCS_SQ_IDLE;
      endcase
    end
  end
  // AHB-Lite slave: address phase captured, data phase answered with zero wait.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_sel_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_off_q <= 8'h00;
    end else if (hready) begin
      ap_sel_q <= hsel && htrans[1];
      ap_wr_q <= hwrite;
      ap_off_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_mode_q <= 1'b0;
      addr_q <= 21'h000000;
      data_q <= 16'h0000;
      f_byte_n <= 1'b1;
    end else if (ap_sel_q && ap_wr_q && !busy_q) begin
      if (ap_off_q == `FCS_OFF_TIME) begin
        byte_mode_q <= hwdata[0];
        f_byte_n <= !hwdata[0];
      end
      if (ap_off_q == `FCS_OFF_ADDR) addr_q <= hwdata[20:0];
      if (ap_off_q == `FCS_OFF_DATA) data_q <= hwdata[15:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= 32'h00000000;
      if (hsel && htrans[1] && !hwrite && hready) begin
        unique case (haddr[7:0])
          `FCS_OFF_CTRL: hrdata <= {28'h0000000, op_q};
          `FCS_OFF_ADDR: hrdata <= {11'h000, addr_q};
          `FCS_OFF_DATA: hrdata <= {16'h0000, data_q};
          `FCS_OFF_STAT: hrdata <= {16'h0000, last_stat_q, 1'b0, !rb_s3_q, bypass_q,
            timeout_q, fail_q, done_q, busy_q, rb_s_q[1] == rb_s3_q};
          `FCS_OFF_RDAT: hrdata <= {16'h0000, rdat_q};
          `FCS_OFF_TIME: hrdata <= {31'h00000000, byte_mode_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/fcs_host_sva.sv
/*
 Assertions on the flash pins of fcs_host.
 Assumes a bind to fcs_host and a single hclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module fcs_host_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [20:0] f_addr,
  input wire logic [15:0] f_dq_out,
  input wire logic f_dq_oe_n,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic f_byte_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence wr_of(logic [7:0] c);
    $fell(f_we_n) && f_dq_out[7:0] == c;
  endsequence
  write_frame_a: assert property (!f_we_n |-> !f_ce_n && f_oe_n && !f_dq_oe_n)
    else $error("write strobe outside its frame");
  read_float_a: assert property (!f_oe_n |-> !f_ce_n && f_dq_oe_n)
    else $error("data driven during a read");
  ce_lead_a: assert property ($fell(f_ce_n) |=> $fell(f_we_n) || $fell(f_oe_n))
    else $error("strobe did not follow chip enable");
  pulse_width_a: assert property ($fell(f_we_n) |-> !f_we_n [*8])
    else $error("write pulse too short");
  word_first_a: assert property (wr_of(8'haa) ##0 f_byte_n |-> f_addr[10:0] == 11'h555)
    else $error("first unlock address wrong in word mode");
  word_second_a: assert property (wr_of(8'h55) ##0 f_byte_n |-> f_addr[10:0] == 11'h2aa)
    else $error("second unlock address wrong in word mode");
  byte_first_a: assert property (wr_of(8'haa) ##0 !f_byte_n |-> f_addr[11:0] == 12'haaa)
    else $error("first unlock address wrong in byte mode");
  byte_second_a: assert property (wr_of(8'h55) ##0 !f_byte_n |-> f_addr[11:0] == 12'h555)
    else $error("second unlock address wrong in byte mode");
  upper_addr_a: assert property (wr_of(8'haa) |-> f_addr[20:12] == 9'h000)
    else $error("upper address lines set in unlock write");
  unlock_pair_a: assert property (wr_of(8'haa) |-> ##[10:300] wr_of(8'h55))
    else $error("unlock pair incomplete");
endmodule
`default_nettype wire

// File: testbench/fcs_flash_model.sv
/*
 Behavioural parallel flash: command decoder, array, status byte.
 Assumes strobes from fcs_host; erase and program times are shortened.
*/
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
  parameter logic [15:0] ID_WORD = 16'h5a3c,
  parameter logic [15:0] CFI_WORD = 16'h0051,
  parameter logic [4:0] PROT_BLK = 5'h1f
) (
  input wire logic [20:0] f_addr,
  input wire logic [15:0] f_dq_out,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic f_byte_n,
  output logic [15:0] f_dq_in,
  output logic ready_busy_out
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] rd = 16'h0;
  logic [15:0] wd = 16'h0;
  logic [11:0] a;
  logic [7:0] d;
  logic [4:0] blk = 5'h0;
  logic byp = 1'b0, busy = 1'b0, err = 1'b0, win = 1'b0;
  logic susp = 1'b0, tog = 1'b0, alt = 1'b0, ers = 1'b0;
  int st = 0, mode = 0, gen = 0;
  // A released bus shows the inverse of the last value, so a late sample cannot pass.
  assign f_dq_in = (!f_oe_n && !f_ce_n) ? rd : ~rd;
  assign ready_busy_out = !(busy || (ers && !susp));
  function automatic logic [15:0] rdm(input logic [20:0] k);
    return mem.exists(k) ? mem[k] : 16'hffff;
  endfunction
  task automatic erase_run(input int g);
    win = 1'b1;
    #5000;
    if (g == gen) begin
      foreach (mem[k]) if (k[20:16] == blk) mem[k] = 16'hffff;
      ers = 1'b0;
      win = 1'b0;
    end
  endtask
  task automatic arm();
    gen++;
    fork
      begin
        automatic int g = gen;
        #50000;
        if (g == gen) erase_run(g);
      end
    join_none
  endtask
  task automatic prog(input logic [20:0] pa, input logic [15:0] v);
    logic [15:0] old;
    old = rdm(pa);
    wd = v;
    busy = 1'b1;
    st = 0;
    if (pa[20:16] == PROT_BLK) begin
      #1000;
      busy = 1'b0;
      return;
    end
    #2000;
    mem[pa] = old & v;
    err = |(v & ~old);
    busy = 1'b0;
  endtask
  always @(negedge f_oe_n) if (!f_ce_n) begin
    if (busy || err || (ers && (!susp || f_addr[20:16] == blk))) begin
      rd = {8'h00, (ers ? susp : ~wd[7]), tog, err, 1'b0, win, alt, 2'b00};
      if (!susp) tog = !tog;
      if ((ers || err) && f_addr[20:16] == blk) alt = !alt;
    end else rd = mode == 2 ? CFI_WORD : mode == 1 ? ID_WORD : rdm(f_addr);
  end
  always @(posedge f_we_n) if (!f_ce_n) begin
    a = f_byte_n ? {1'b0, f_addr[10:0]} : f_addr[11:0];
    d = f_dq_out[7:0];
    if (busy) st = 0;
    else if (ers && !susp) begin
      if (d == 8'hb0) begin
        susp = 1'b1;
        gen++;
      end else if (d == 8'h30 && !win) arm();
    end else if (d == 8'hf0) begin
      err = 1'b0;
      mode = 0;
      st = 0;
    end else if (err) st = 0;
    else if (st == 0 && d == 8'h30 && susp) begin
      susp = 1'b0;
      gen++;
      fork erase_run(gen); join_none
    end else if (st == 0 && !byp && d == 8'h98 && a == (f_byte_n ? 12'h055 : 12'h0aa)
                 && mode < 2) mode = 2;
    else if (st == 3 || st == 7) prog(f_addr, f_byte_n ? f_dq_out : {8'hff, d});
    else if (st == 8) begin
      byp = d != 8'h00;
      st = 0;
    end else if (byp) st = d == 8'ha0 ? 7 : d == 8'h90 ? 8 : 0;
    else if (a == (f_byte_n ? 12'h555 : 12'haaa) && d == 8'haa && (st == 0 || st == 4)) st++;
    else if (a == (f_byte_n ? 12'h2aa : 12'h555) && d == 8'h55 && (st == 1 || st == 5)) st++;
    else if (st == 2 && a == (f_byte_n ? 12'h555 : 12'haaa)) begin
      st = d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
      if (d == 8'h90) mode = 1;
      if (d == 8'h20) byp = 1'b1;
    end else if (st == 6 && d == 8'h10 && a == (f_byte_n ? 12'h555 : 12'haaa)) begin
      st = 0;
      wd = 16'hffff;
      busy = 1'b1;
      win = 1'b1;
      #5000;
      mem.delete();
      busy = 1'b0;
      win = 1'b0;
    end else if (st == 6 && d == 8'h30) begin
      st = 0;
      blk = f_addr[20:16];
      ers = 1'b1;
      wd = 16'hffff;
      arm();
    end else st = 0;
  end
endmodule
`default_nettype wire

// File: testbench/test_fcs_host.sv
/*
 Self-checking bench of fcs_host with a behavioural flash on its pins.
 Assumes the design files, the checker and the flash model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcs_defines.svh"
module test_fcs_host;
  localparam logic [15:0] ID_WORD = 16'h5a3c; // Arbitrary identifier value.
  localparam logic [15:0] CFI_WORD = 16'h0051;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, f_dq_oe_n, f_ce_n, f_we_n, f_oe_n, f_byte_n, ready_busy_out;
  logic [31:0] hrdata, r;
  logic [31:0] seed = 32'h13ffe;
  logic [20:0] f_addr, pa;
  logic [15:0] f_dq_out, f_dq_in, pv, pv2;
  logic [1:0] tg;
  int num_errors = 0;
  int checks_done = 0;
  always #2.5 hclk = ~hclk;
  fcs_host #(.POLL_LIMIT(2000)) i_fcs_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .f_addr(f_addr), .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n), .f_dq_in(f_dq_in),
    .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_byte_n(f_byte_n),
    .ready_busy_out(ready_busy_out));
  fcs_flash_model #(.ID_WORD(ID_WORD), .CFI_WORD(CFI_WORD)) i_fcs_flash_model (
    .f_addr(f_addr), .f_dq_out(f_dq_out), .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n),
    .f_byte_n(f_byte_n), .f_dq_in(f_dq_in), .ready_busy_out(ready_busy_out));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Busy is polled through the status register, bounded; the watchdog ends real hangs.
  task automatic run(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d);
    int n;
    ahb(1'b1, `FCS_OFF_ADDR, {11'h0, a});
    ahb(1'b1, `FCS_OFF_DATA, {16'h0, d});
    ahb(1'b1, `FCS_OFF_CTRL, {28'h0, op});
    n = 0;
    do begin
      ahb(1'b0, `FCS_OFF_STAT, 32'h0);
      n++;
    end while (r[1] !== 1'b0 && n < 3000);
    if (r[1] !== 1'b0) num_errors++;
  endtask
  task automatic rd(input logic [20:0] a);
    run(`FCS_OP_READ, a, 16'h0);
    ahb(1'b0, `FCS_OFF_RDAT, 32'h0);
  endtask
  task automatic pl(input logic [20:0] a);
    run(`FCS_OP_POLL, a, 16'h0);
    ahb(1'b0, `FCS_OFF_RDAT, 32'h0);
  endtask
  task automatic pick();
    r = xs();
    pa = {1'b0, r[19:0]};
    r = xs();
    pv = r[15:0] | 16'h0003;
  endtask
  initial begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `FCS_OFF_RDAT, 32'h0);
    cmp(r, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    cmp(r, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      pick();
      run(`FCS_OP_PROGRAM, pa, pv);
      rd(pa);
      cmp(r[15:0], pv);
    end
    pv2 = ~pv | 16'h0003;
    run(`FCS_OP_PROGRAM, pa, pv2);
    cmp(r[3], 1'b1);
    run(`FCS_OP_RESET, 21'h0, 16'h0);
    cmp(r[3], 1'b0);
    rd(pa);
    cmp(r[15:0], pv & pv2);
    run(`FCS_OP_PROGRAM, {5'h1f, 16'h0040}, 16'h1233);
    rd({5'h1f, 16'h0040});
    cmp(r[15:0], 16'hffff);
    $display("test program done");
    run(`FCS_OP_BYPASS, 21'h0, 16'h0);
    cmp(r[5], 1'b1);
    for (int i = 0; i < 2; i++) begin
      pick();
      run(`FCS_OP_BYP_PROG, pa, pv);
      rd(pa);
      cmp(r[15:0], pv);
      run(`FCS_OP_RESET, 21'h0, 16'h0);
    end
    run(`FCS_OP_BYP_EXIT, 21'h0, 16'h0);
    cmp(r[5], 1'b0);
    $display("test bypass done");
    ahb(1'b1, `FCS_OFF_TIME, 32'h1);
    pick();
    run(`FCS_OP_PROGRAM, pa, pv);
    rd(pa);
    cmp(r[7:0], pv[7:0]);
    ahb(1'b1, `FCS_OFF_TIME, 32'h0);
    run(`FCS_OP_AUTOSEL, 21'h0, 16'h0);
    rd(21'h0);
    cmp(r[15:0], ID_WORD);
    run(`FCS_OP_CFI, 21'h0, 16'h0);
    rd(21'h0);
    cmp(r[15:0], CFI_WORD);
    run(`FCS_OP_RESET, 21'h0, 16'h0);
    run(`FCS_OP_RESET, 21'h0, 16'h0);
    $display("test byte mode and identifier done");
    run(`FCS_OP_CHIP_ERASE, 21'h0, 16'h0);
    rd(pa);
    cmp(r[15:0], 16'hffff);
    pa = {5'h03, 16'h0100};
    run(`FCS_OP_PROGRAM, pa, 16'h1233);
    run(`FCS_OP_BLOCK_ERASE, pa, 16'h0);
    pl(pa);
    cmp({r[7], r[3]}, 2'b00);
    tg = {r[6], r[2]};
    pl(pa);
    cmp({r[6], r[2]}, {~tg});
    ahb(1'b0, `FCS_OFF_STAT, 32'h0);
    cmp(r[6], 1'b1);
    run(`FCS_OP_SUSPEND, pa, 16'h0);
    pl(pa);
    cmp(r[7], 1'b1);
    ahb(1'b0, `FCS_OFF_STAT, 32'h0);
    cmp(r[6], 1'b0);
    run(`FCS_OP_RESUME, pa, 16'h0);
    rd(pa);
    cmp(r[15:0], 16'hffff);
    $display("test erase done");
    close_out();
  end
endmodule
bind fcs_host fcs_host_sva i_fcs_host_sva (.hclk(hclk), .hresetn(hresetn), .f_addr(f_addr),
  .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n), .f_ce_n(f_ce_n), .f_we_n(f_we_n),
  .f_oe_n(f_oe_n), .f_byte_n(f_byte_n));
`default_nettype wire
